// ### src/drc_pkg.sv
// Constants, codes and carrier types for the disturbance recorder control block
package drc_pkg;

   localparam int CLK_MHZ = 40;
   localparam int BIN_PERIOD_US = 5000;
   localparam int TICK_CYCLES = CLK_MHZ * BIN_PERIOD_US;

   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_CLR_IDX = 8'h08;
   localparam logic [7:0] OFF_MAN_TRIG = 8'h0C;
   localparam logic [7:0] OFF_CLR_ALL = 8'h10;
   localparam logic [7:0] OFF_CLR_NEW = 8'h14;
   localparam logic [7:0] OFF_CLR_OLD = 8'h18;
   localparam logic [7:0] OFF_REC_COUNT = 8'h1C;
   localparam logic [7:0] OFF_MAX_REC = 8'h20;
   localparam logic [7:0] OFF_MAX_LEN = 8'h24;
   localparam logic [7:0] OFF_MAX_PRE = 8'h28;
   localparam logic [7:0] OFF_TRIG_LO = 8'h2C;
   localparam logic [7:0] OFF_TRIG_HI = 8'h30;
   localparam logic [7:0] OFF_SAMP_LO = 8'h34;
   localparam logic [7:0] OFF_SAMP_HI = 8'h38;
   localparam logic [7:0] OFF_ANALOG = 8'h3C;
   localparam logic [7:0] OFF_SPC = 8'h40;
   localparam logic [7:0] OFF_BIN_CNT = 8'h44;
   localparam logic [7:0] OFF_LEN = 8'h48;
   localparam logic [7:0] OFF_PRE = 8'h4C;
   localparam logic [7:0] OFF_OLD_TIME = 8'h50;
   localparam logic [7:0] OFF_NEW_TIME = 8'h54;

   localparam logic REC_ENABLED = 1'h0;
   localparam logic REC_DISABLED = 1'h1;
   localparam logic [31:0] CMD_TRIG = 32'h0000_0001;
   localparam logic [31:0] CMD_CLEAR = 32'h0000_0001;

   localparam logic [2:0] ST_READY = 3'h0;
   localparam logic [2:0] ST_TRIGGERED = 3'h1;
   localparam logic [2:0] ST_RECORDING = 3'h2;
   localparam logic [2:0] ST_STORING = 3'h3;
   localparam logic [2:0] ST_FULL = 3'h4;
   localparam logic [2:0] ST_BAD_CFG = 3'h5;

   localparam logic [6:0] MAX_RECORDS = 7'h64;
   localparam int NUM_EXT = 32;
   localparam int NUM_CH = 40;
   localparam int CH_CONST0 = 32;
   localparam int CH_CONST1 = 33;
   localparam int CH_PHASE = 34;
   localparam int CH_SYNC = 35;
   localparam int CH_FAULT = 36;

   localparam logic [5:0] NOM_HZ = 6'h32;
   localparam logic [7:0] BIN_SPS = 8'(1000000 / BIN_PERIOD_US);
   localparam logic [39:0] MEM_SAMPLES = 40'h00_0080_0000;
   localparam logic [39:0] REC_NUM = MEM_SAMPLES * 40'h64;
   localparam logic [39:0] LEN_NUM = MEM_SAMPLES * 40'h3E8;
   localparam logic [20:0] MAX_LEN_MS = 21'h1B_7740;
   localparam logic [20:0] MAX_PRE_MS = 21'h00_7530;
   localparam logic [4:0] MAX_ANALOG = 5'h14;
   localparam logic [17:0] LEN_MIN_CS = 18'h0_000A;
   localparam logic [17:0] LEN_MAX_CS = 18'h2_BF20;
   localparam logic [8:0] PRE_MIN_DS = 9'h002;
   localparam logic [8:0] PRE_MAX_DS = 9'h12C;
   localparam logic [3:0] CS_TO_MS = 4'hA;
   localparam logic [6:0] DS_TO_MS = 7'h64;
   localparam logic [4:0] DS_TO_TICKS = 5'h14;
   localparam logic [18:0] STORE_TICKS = 19'h0_0004;
   localparam logic [5:0] DIV_STEPS = 6'h28;

   localparam logic [4:0] RST_ANALOG = 5'h08;
   localparam logic [1:0] RST_SPC = 2'h0;
   localparam logic [5:0] RST_BIN_CNT = 6'h08;
   localparam logic [17:0] RST_LEN = 18'h0_0064;
   localparam logic [8:0] RST_PRE = 9'h002;
   localparam logic [39:0] RST_TRIG_MASK = 40'h00_0000_0000;

   typedef struct packed {
      logic [7:0] addr;
      logic rd;
      logic wr;
      logic [31:0] wdata;
   } drc_bus_req_t;

   typedef struct packed {
      logic [6:0] max_rec;
      logic [20:0] max_len_ms;
      logic [20:0] max_pre_ms;
   } drc_limits_t;

   function automatic logic [6:0] drc_spc(input logic [1:0] code);
      drc_spc = 7'h40 >> code;
   endfunction

endpackage

// ### src/drc_tick.sv
// Divider that makes the one-cycle binary sampling enable
module drc_tick import drc_pkg::*; #(
   parameter int TICK_CYCLES_P = TICK_CYCLES
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   output logic tick_out
);
   localparam logic [17:0] LAST = 18'(TICK_CYCLES_P - 1);

   logic [17:0] cnt_q;
   wire at_last = cnt_q == LAST;

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt_q <= 18'h0_0000;
         tick_out <= 1'b0;
      end else begin
         cnt_q <= at_last ? 18'h0_0000 : cnt_q + 18'h0_0001;
         tick_out <= at_last;
      end
   end
endmodule

// ### src/drc_recorder_top.sv
// Disturbance recorder control: sampling, triggering, record list and limits
//
// The address map and register access over Avalon-MM were left to the implementer.
module drc_recorder_top import drc_pkg::*; #(
   parameter int TICK_CYCLES_P = TICK_CYCLES
) (
   input wire logic CLOCK_IN,
   input wire logic RST_B_IN,
   input wire logic [7:0] AVS_ADDRESS_IN,
   input wire logic AVS_READ_IN,
   input wire logic AVS_WRITE_IN,
   input wire logic [31:0] AVS_WRITEDATA_IN,
   output logic [31:0] AVS_READDATA_OUT,
   output logic AVS_WAITREQUEST_OUT,
   input wire logic [31:0] BIN_CH_IN,
   input wire logic PHASE_ORDER_REVERSED_IN,
   input wire logic TIME_SYNC_LOST_FLAG_IN,
   input wire logic INTERNAL_FAULT_IN,
   output logic [2:0] STATUS_OUT,
   output logic [6:0] REC_COUNT_OUT,
   output logic [39:0] BIN_SAMPLE_OUT
);
   typedef enum logic [1:0] {S_IDLE, S_TRIG, S_REC, S_STORE} drc_state_t;
   typedef enum logic [1:0] {C_IDLE, C_REC, C_LEN} drc_calc_t;

   // Reset release
   logic rst_s1_q, rst_n;
   always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         rst_s1_q <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n <= rst_s1_q;
      end
   end

   // Bus slave: one wait cycle, held off while the record list compacts
   drc_bus_req_t req;
   assign req = '{addr: AVS_ADDRESS_IN, rd: AVS_READ_IN, wr: AVS_WRITE_IN,
                  wdata: AVS_WRITEDATA_IN};
   logic ack_q, busy_q;
   wire ack_d = (req.rd | req.wr) & ~ack_q & ~busy_q;
   wire wr_go = ack_q & req.wr;
   wire [31:0] wd = req.wdata;

   wire w_ctrl = wr_go & (req.addr == OFF_CTRL);
   wire w_idx = wr_go & (req.addr == OFF_CLR_IDX);
   wire w_man = wr_go & (req.addr == OFF_MAN_TRIG);
   wire w_all = wr_go & (req.addr == OFF_CLR_ALL);
   wire w_new = wr_go & (req.addr == OFF_CLR_NEW);
   wire w_old = wr_go & (req.addr == OFF_CLR_OLD);
   wire w_tlo = wr_go & (req.addr == OFF_TRIG_LO);
   wire w_thi = wr_go & (req.addr == OFF_TRIG_HI);
   wire w_ana = wr_go & (req.addr == OFF_ANALOG);
   wire w_spc = wr_go & (req.addr == OFF_SPC);
   wire w_bin = wr_go & (req.addr == OFF_BIN_CNT);
   wire w_len = wr_go & (req.addr == OFF_LEN);
   wire w_pre = wr_go & (req.addr == OFF_PRE);
   wire cfg_wr = w_ana | w_spc | w_bin | w_len | w_pre;

   // Settings
   logic disable_q;
   logic [39:0] trig_mask_q;
   logic [4:0] analog_q;
   logic [1:0] spc_q;
   logic [5:0] bin_cnt_q;
   logic [17:0] len_q;
   logic [8:0] pre_q;
   always_ff @(posedge CLOCK_IN or negedge rst_n) begin
      if (!rst_n) begin
         disable_q <= REC_ENABLED;
         trig_mask_q <= RST_TRIG_MASK;
         analog_q <= RST_ANALOG;
         spc_q <= RST_SPC;
         bin_cnt_q <= RST_BIN_CNT;
         len_q <= RST_LEN;
         pre_q <= RST_PRE;
      end else begin
         if (w_ctrl) disable_q <= wd[0];
         if (w_tlo) trig_mask_q[31:0] <= wd;
         if (w_thi) trig_mask_q[39:32] <= wd[7:0];
         if (w_ana) analog_q <= wd[4:0];
         if (w_spc) spc_q <= wd[1:0];
         if (w_bin) bin_cnt_q <= wd[5:0];
         if (w_len) len_q <= wd[17:0];
         if (w_pre) pre_q <= wd[8:0];
      end
   end

   // Binary channel sampling on the 5 ms enable
   logic tick;
   drc_tick #(.TICK_CYCLES_P(TICK_CYCLES_P)) u_tick (
      .clk_in(CLOCK_IN),
      .rst_n_in(rst_n),
      .tick_out(tick)
   );

   wire [NUM_CH-1:0] chan;
   assign chan[NUM_EXT-1:0] = BIN_CH_IN;
   assign chan[CH_CONST0] = 1'b0;
   assign chan[CH_CONST1] = 1'b1;
   assign chan[CH_PHASE] = PHASE_ORDER_REVERSED_IN;
   assign chan[CH_SYNC] = TIME_SYNC_LOST_FLAG_IN;
   assign chan[CH_FAULT] = INTERNAL_FAULT_IN;
   assign chan[NUM_CH-1:CH_FAULT+1] = 3'h0;

   logic [NUM_CH-1:0] prev_q;
   logic samp_new_q;
   logic [31:0] time_q;
   always_ff @(posedge CLOCK_IN or negedge rst_n) begin
      if (!rst_n) begin
         BIN_SAMPLE_OUT <= 40'h00_0000_0000;
         prev_q <= 40'h00_0000_0000;
         samp_new_q <= 1'b0;
         time_q <= 32'h0000_0000;
      end else begin
         samp_new_q <= tick;
         if (tick) begin
            BIN_SAMPLE_OUT <= chan;
            prev_q <= BIN_SAMPLE_OUT;
            time_q <= time_q + 32'h0000_0001;
         end
      end
   end

   // Any channel may be a trigger source; only a fresh rise counts
   wire [NUM_CH-1:0] rise;
   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++) begin : g_rise
         assign rise[g] = BIN_SAMPLE_OUT[g] & ~prev_q[g] & trig_mask_q[g];
      end
   endgenerate
   wire auto_trig = samp_new_q & (|rise);

   // Capacity figures
   wire [17:0] sps = 18'(analog_q * drc_spc(spc_q) * NOM_HZ) + 18'(bin_cnt_q * BIN_SPS);
   wire [39:0] size_prod = 40'(sps) * 40'(len_q);
   wire [20:0] len_ms = 21'(len_q * CS_TO_MS);
   wire [20:0] pre_ms = 21'(pre_q * DS_TO_MS);

   drc_limits_t lim_q;
   drc_calc_t calc_q;
   logic calc_go_q;
   logic [39:0] rem_q, quo_q, dvs_q;
   logic [5:0] step_q;
   wire [39:0] rem_sh = {rem_q[38:0], quo_q[39]};
   wire [40:0] trial = {1'b0, rem_sh} - {1'b0, dvs_q};
   wire fits = ~trial[40];
   wire [39:0] quo_nx = {quo_q[38:0], fits};
   wire last_step = step_q == DIV_STEPS - 6'h01;
   wire [6:0] rec_cap = (quo_nx > 40'(MAX_RECORDS)) ? MAX_RECORDS : quo_nx[6:0];
   wire [20:0] len_cap = (quo_nx > 40'(MAX_LEN_MS)) ? MAX_LEN_MS : quo_nx[20:0];
   wire [20:0] pre_a = (len_ms < len_cap) ? len_ms : len_cap;
   wire [20:0] pre_cap = (pre_a < MAX_PRE_MS) ? pre_a : MAX_PRE_MS;

   // Serial division keeps the limit logic small; figures lag a write by about 80 cycles
   always_ff @(posedge CLOCK_IN or negedge rst_n) begin
      if (!rst_n) begin
         calc_q <= C_IDLE;
         calc_go_q <= 1'b1;
         lim_q <= '0;
         rem_q <= 40'h00_0000_0000;
         quo_q <= 40'h00_0000_0000;
         dvs_q <= 40'h00_0000_0000;
         step_q <= 6'h00;
      end else begin
         unique case (calc_q)
            C_IDLE: begin
               calc_go_q <= cfg_wr;
               if (calc_go_q) begin
                  if (sps == 18'h0_0000) begin
                     lim_q <= '0;
                  end else begin
                     calc_q <= C_REC;
                     rem_q <= 40'h00_0000_0000;
                     quo_q <= REC_NUM;
                     dvs_q <= size_prod;
                     step_q <= 6'h00;
                  end
               end
            end
            C_REC: begin
               calc_go_q <= calc_go_q | cfg_wr;
               rem_q <= fits ? trial[39:0] : rem_sh;
               quo_q <= quo_nx;
               step_q <= step_q + 6'h01;
               if (last_step) begin
                  lim_q.max_rec <= rec_cap;
                  calc_q <= C_LEN;
                  rem_q <= 40'h00_0000_0000;
                  quo_q <= LEN_NUM;
                  dvs_q <= 40'(sps);
                  step_q <= 6'h00;
               end
            end
            C_LEN: begin
               calc_go_q <= calc_go_q | cfg_wr;
               rem_q <= fits ? trial[39:0] : rem_sh;
               quo_q <= quo_nx;
               step_q <= step_q + 6'h01;
               if (last_step) begin
                  lim_q.max_len_ms <= len_cap;
                  lim_q.max_pre_ms <= pre_cap;
                  calc_q <= C_IDLE;
               end
            end
         endcase
      end
   end

   wire cfg_bad = (sps == 18'h0_0000) | (analog_q > MAX_ANALOG) | (len_q < LEN_MIN_CS)
                | (len_q > LEN_MAX_CS) | (pre_q < PRE_MIN_DS) | (pre_q > PRE_MAX_DS)
                | (lim_q.max_rec == 7'h00) | (len_ms > lim_q.max_len_ms)
                | (pre_ms > len_ms);
   wire [6:0] cap = (lim_q.max_rec < MAX_RECORDS) ? lim_q.max_rec : MAX_RECORDS;

   // Record list, oldest first
   logic [31:0] rec_time_q [0:99];
   logic [6:0] count_q;
   logic [6:0] sh_q;
   logic [31:0] stamp_q;
   wire full = count_q >= cap;
   wire has = count_q != 7'h00;
   wire clr_all = w_all & (wd == CMD_CLEAR);
   wire clr_new = w_new & (wd == CMD_CLEAR) & has;
   wire clr_old = w_old & (wd == CMD_CLEAR) & has;
   wire clr_idx = w_idx & (wd != 32'h0000_0000) & (wd <= 32'(count_q));
   wire cmd_any = clr_all | clr_new | clr_old | clr_idx;
   wire sh_last = sh_q == count_q - 7'h01;

   // Manual trigger pending bit: a new write wins over the consuming clear
   logic man_q;
   drc_state_t st_q;
   logic [18:0] tk_q;
   wire idle = st_q == S_IDLE;
   wire can_start = ~disable_q & ~full & ~cfg_bad;
   wire start = idle & (man_q | auto_trig) & can_start;
   wire store_done = (st_q == S_STORE) & (tk_q == 19'h0_0000);
   wire append = store_done & ~busy_q & ~cmd_any & (count_q < MAX_RECORDS);
   wire [18:0] len_tk = {len_q, 1'b0};
   wire [18:0] pre_tk = 19'(pre_q * DS_TO_TICKS);
   wire [18:0] rec_tk = (len_tk > pre_tk) ? len_tk - pre_tk : 19'h0_0001;

   always_ff @(posedge CLOCK_IN or negedge rst_n) begin
      if (!rst_n) begin
         man_q <= 1'b0;
      end else if (w_man & (wd == CMD_TRIG)) begin
         man_q <= 1'b1;
      end else if (idle) begin
         man_q <= 1'b0;
      end
   end

   always_ff @(posedge CLOCK_IN or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= S_IDLE;
         tk_q <= 19'h0_0000;
         stamp_q <= 32'h0000_0000;
      end else begin
         unique case (st_q)
            S_IDLE: if (start) begin
               st_q <= S_TRIG;
               stamp_q <= time_q;
            end
            S_TRIG: if (tick) begin
               st_q <= S_REC;
               tk_q <= rec_tk;
            end
            S_REC: if (tick) begin
               if (tk_q <= 19'h0_0001) begin
                  st_q <= S_STORE;
                  tk_q <= STORE_TICKS;
               end else begin
                  tk_q <= tk_q - 19'h0_0001;
               end
            end
            S_STORE: begin
               if (tick & (tk_q != 19'h0_0000)) tk_q <= tk_q - 19'h0_0001;
               if (store_done & (append | (count_q >= MAX_RECORDS))) st_q <= S_IDLE;
            end
         endcase
      end
   end

   // List control: a clear by position shifts later entries down, one per cycle
   always_ff @(posedge CLOCK_IN or negedge rst_n) begin
      if (!rst_n) begin
         count_q <= 7'h00;
         busy_q <= 1'b0;
         sh_q <= 7'h00;
      end else if (clr_all) begin
         count_q <= 7'h00;
      end else if (clr_new) begin
         count_q <= count_q - 7'h01;
      end else if (clr_old) begin
         busy_q <= 1'b1;
         sh_q <= 7'h00;
      end else if (clr_idx) begin
         busy_q <= 1'b1;
         sh_q <= wd[6:0] - 7'h01;
      end else if (busy_q) begin
         if (sh_last) begin
            busy_q <= 1'b0;
            count_q <= count_q - 7'h01;
         end else begin
            sh_q <= sh_q + 7'h01;
         end
      end else if (append) begin
         count_q <= count_q + 7'h01;
      end
   end

   always_ff @(posedge CLOCK_IN) begin
      if (busy_q & ~sh_last) rec_time_q[sh_q] <= rec_time_q[sh_q + 7'h01];
      if (append) rec_time_q[count_q] <= stamp_q;
   end

   // Status and read data
   wire [2:0] status_d = cfg_bad ? ST_BAD_CFG :
                         (st_q == S_TRIG) ? ST_TRIGGERED :
                         (st_q == S_REC) ? ST_RECORDING :
                         (st_q == S_STORE) ? ST_STORING :
                         full ? ST_FULL : ST_READY;
   wire [31:0] old_t = has ? rec_time_q[0] : 32'h0000_0000;
   wire [31:0] new_t = has ? rec_time_q[count_q - 7'h01] : 32'h0000_0000;
   wire [7:0] a = req.addr;
   wire [31:0] rdata =
      (a == OFF_CTRL) ? {31'h0, disable_q} :
      (a == OFF_STATUS) ? {29'h0, STATUS_OUT} :
      (a == OFF_MAN_TRIG) ? {31'h0, man_q} :
      (a == OFF_REC_COUNT) ? {25'h0, count_q} :
      (a == OFF_MAX_REC) ? {25'h0, lim_q.max_rec} :
      (a == OFF_MAX_LEN) ? {11'h0, lim_q.max_len_ms} :
      (a == OFF_MAX_PRE) ? {11'h0, lim_q.max_pre_ms} :
      (a == OFF_TRIG_LO) ? trig_mask_q[31:0] :
      (a == OFF_TRIG_HI) ? {24'h0, trig_mask_q[39:32]} :
      (a == OFF_SAMP_LO) ? BIN_SAMPLE_OUT[31:0] :
      (a == OFF_SAMP_HI) ? {24'h0, BIN_SAMPLE_OUT[39:32]} :
      (a == OFF_ANALOG) ? {27'h0, analog_q} :
      (a == OFF_SPC) ? {30'h0, spc_q} :
      (a == OFF_BIN_CNT) ? {26'h0, bin_cnt_q} :
      (a == OFF_LEN) ? {14'h0, len_q} :
      (a == OFF_PRE) ? {23'h0, pre_q} :
      (a == OFF_OLD_TIME) ? old_t :
      (a == OFF_NEW_TIME) ? new_t : 32'h0000_0000;

   always_ff @(posedge CLOCK_IN or negedge rst_n) begin
      if (!rst_n) begin
         ack_q <= 1'b0;
         AVS_WAITREQUEST_OUT <= 1'b1;
         AVS_READDATA_OUT <= 32'h0000_0000;
         STATUS_OUT <= ST_READY;
         REC_COUNT_OUT <= 7'h00;
      end else begin
         ack_q <= ack_d;
         AVS_WAITREQUEST_OUT <= ~ack_d;
         if (ack_d & req.rd) AVS_READDATA_OUT <= rdata;
         STATUS_OUT <= status_d;
         REC_COUNT_OUT <= count_q;
      end
   end
endmodule

// ### verif/drc_recorder_chk.sv
// Port-level assertions for the recorder control block
module drc_recorder_chk import drc_pkg::*; #(
   parameter int TICK_CYCLES_P = TICK_CYCLES
) (
   input wire logic CLOCK_IN,
   input wire logic RST_B_IN,
   input wire logic AVS_WAITREQUEST_OUT,
   input wire logic [31:0] BIN_CH_IN,
   input wire logic PHASE_ORDER_REVERSED_IN,
   input wire logic TIME_SYNC_LOST_FLAG_IN,
   input wire logic INTERNAL_FAULT_IN,
   input wire logic [2:0] STATUS_OUT,
   input wire logic [6:0] REC_COUNT_OUT,
   input wire logic [39:0] BIN_SAMPLE_OUT
);
   default clocking @(posedge CLOCK_IN); endclocking
   default disable iff (!RST_B_IN);
   int gap_q;
   logic seen_q;
   // Cycles since the sample last moved; only ticks may move it
   always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         gap_q <= 0;
         seen_q <= 1'b0;
      end else if ($changed(BIN_SAMPLE_OUT)) begin
         gap_q <= 1;
         seen_q <= 1'b1;
      end else begin
         gap_q <= gap_q + 1;
      end
   end
   sequence s_steady;
      $stable({INTERNAL_FAULT_IN, TIME_SYNC_LOST_FLAG_IN, PHASE_ORDER_REVERSED_IN, BIN_CH_IN})[*3];
   endsequence
   sequence s_trig_end; STATUS_OUT == ST_TRIGGERED ##1 STATUS_OUT != ST_TRIGGERED; endsequence
   sequence s_store_end; STATUS_OUT == ST_STORING ##1 STATUS_OUT != ST_STORING; endsequence
   property p_ans_one; !AVS_WAITREQUEST_OUT |=> AVS_WAITREQUEST_OUT; endproperty
   a_ans_one: assert property (p_ans_one)
      else $error("waitrequest low for more than one cycle");
   property p_st_code; STATUS_OUT <= ST_BAD_CFG; endproperty
   a_st_code: assert property (p_st_code)
      else $error("status code out of range");
   property p_cnt_cap; REC_COUNT_OUT <= MAX_RECORDS; endproperty
   a_cnt_cap: assert property (p_cnt_cap)
      else $error("record count above limit");
   property p_smp_val;
      s_steady ##0 $changed(BIN_SAMPLE_OUT) |-> BIN_SAMPLE_OUT == {3'h0, INTERNAL_FAULT_IN,
         TIME_SYNC_LOST_FLAG_IN, PHASE_ORDER_REVERSED_IN, 2'h2, BIN_CH_IN};
   endproperty
   a_smp_val: assert property (p_smp_val)
      else $error("sample does not match channel inputs");
   property p_smp_period;
      $changed(BIN_SAMPLE_OUT) && seen_q |-> (gap_q % TICK_CYCLES_P) == 0;
   endproperty
   a_smp_period: assert property (p_smp_period)
      else $error("sample moved off the tick period");
   property p_trig_next; s_trig_end |-> STATUS_OUT == ST_RECORDING; endproperty
   a_trig_next: assert property (p_trig_next)
      else $error("triggered not followed by recording");
   property p_store_end; s_store_end |-> STATUS_OUT inside {ST_READY, ST_FULL}; endproperty
   a_store_end: assert property (p_store_end)
      else $error("storing not followed by ready or full");
   property p_ready_room; STATUS_OUT == ST_READY |-> REC_COUNT_OUT < MAX_RECORDS; endproperty
   a_ready_room: assert property (p_ready_room)
      else $error("ready shown with memory full");
   property p_cnt_step;
      REC_COUNT_OUT > $past(REC_COUNT_OUT) |-> REC_COUNT_OUT == $past(REC_COUNT_OUT) + 7'h01;
   endproperty
   a_cnt_step: assert property (p_cnt_step)
      else $error("record count grew by more than one");
endmodule

bind drc_recorder_top drc_recorder_chk #(.TICK_CYCLES_P(TICK_CYCLES_P)) u_chk (
   .CLOCK_IN(CLOCK_IN), .RST_B_IN(RST_B_IN), .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT),
   .BIN_CH_IN(BIN_CH_IN), .PHASE_ORDER_REVERSED_IN(PHASE_ORDER_REVERSED_IN),
   .TIME_SYNC_LOST_FLAG_IN(TIME_SYNC_LOST_FLAG_IN), .INTERNAL_FAULT_IN(INTERNAL_FAULT_IN),
   .STATUS_OUT(STATUS_OUT), .REC_COUNT_OUT(REC_COUNT_OUT), .BIN_SAMPLE_OUT(BIN_SAMPLE_OUT));

// ### verif/test_disturbance_recorder_control.sv
// Self-checking bench for the recorder control block
module test_disturbance_recorder_control import drc_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   // Short tick keeps a hundred recordings inside the run budget
   localparam int T = 20;
   logic clk, rd = 1'b0, wr = 1'b0, rst_b = 1'b0, ph = 1'b0, syn = 1'b0, flt = 1'b0, wreq;
   logic [7:0] adr = 8'h00;
   logic [31:0] wd = 32'h0, bin = 32'h0, rdat, v, o, nw;
   logic [2:0] st, last_st;
   logic [6:0] cnt;
   logic [39:0] smp;
   logic [2:0] trail[$];
   int errors = 0;
   int compares = 0;
   int exp_cnt = 0;
   logic [7:0] offs[15] = '{OFF_CTRL, OFF_STATUS, OFF_MAN_TRIG, OFF_TRIG_LO, OFF_TRIG_HI,
      OFF_ANALOG, OFF_SPC, OFF_BIN_CNT, OFF_LEN, OFF_PRE, OFF_REC_COUNT, OFF_MAX_REC,
      OFF_MAX_LEN, OFF_MAX_PRE, 8'h7C};
   logic [31:0] exps[15] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h8, 32'h0, 32'h8, 32'h64,
      32'h2, 32'h0, 32'h64, 32'h4_B4B4, 32'h3E8, 32'h0};

   drc_recorder_top #(.TICK_CYCLES_P(T)) DUT (
      .CLOCK_IN(clk), .RST_B_IN(rst_b), .AVS_ADDRESS_IN(adr), .AVS_READ_IN(rd),
      .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wd), .AVS_READDATA_OUT(rdat),
      .AVS_WAITREQUEST_OUT(wreq), .BIN_CH_IN(bin), .PHASE_ORDER_REVERSED_IN(ph),
      .TIME_SYNC_LOST_FLAG_IN(syn), .INTERNAL_FAULT_IN(flt), .STATUS_OUT(st),
      .REC_COUNT_OUT(cnt), .BIN_SAMPLE_OUT(smp));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // Status history, so a one-cycle state is never missed
   always @(posedge clk) begin
      if (st !== last_st) trail.push_back(st);
      last_st = st;
   end

   task automatic end_sim();
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input string what, input logic [39:0] e, input logic [39:0] g);
      compares++;
      if (g !== e) begin
         errors++;
         $display("unexpected %s expected %0h seen %0h", what, e, g);
      end
   endtask

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int n;
      n = 0;
      adr <= a;
      rd <= !w;
      wr <= w;
      wd <= d;
      @(posedge clk);
      while (wreq !== 1'b0) begin
         n++;
         if (n > 500) begin
            errors++;
            end_sim();
         end
         @(posedge clk);
      end
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wrr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0, v);
      chk($sformatf("reg %h", a), {8'h0, e}, {8'h0, v});
   endtask

   task automatic cc(input int e);
      repeat (3) @(posedge clk);
      chk("count", 40'(e), {33'h0, cnt});
   endtask

   task automatic stc(input logic [2:0] e);
      chk("status", {37'h0, e}, {37'h0, st});
   endtask

   task automatic walk(input logic [2:0] fin);
      int n;
      n = 0;
      while (trail.size() < 4) begin
         @(posedge clk);
         n++;
         if (n > 4000) begin
            errors++;
            end_sim();
         end
      end
      chk("walk", {28'h0, ST_TRIGGERED, ST_RECORDING, ST_STORING, fin},
          {28'h0, trail[0], trail[1], trail[2], trail[3]});
      exp_cnt++;
      cc(exp_cnt);
   endtask

   initial begin
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      repeat (150) @(posedge clk);
      for (int i = 0; i < 15; i++) rdc(offs[i], exps[i]);
      bin <= 32'hA5C3_0F96;
      ph <= 1'b1;
      syn <= 1'b1;
      repeat (3 * T) @(posedge clk);
      chk("sample", 40'h0E_A5C3_0F96, smp);
      bin <= 32'h5A3C_F069;
      ph <= 1'b0;
      syn <= 1'b0;
      flt <= 1'b1;
      repeat (3 * T) @(posedge clk);
      rdc(OFF_SAMP_HI, 32'h12);
      rdc(OFF_SAMP_LO, 32'h5A3C_F069);
      bin <= 32'h0;
      wrr(OFF_LEN, 32'h3E8);
      repeat (150) @(posedge clk);
      rdc(OFF_MAX_REC, 32'h1E);
      rdc(OFF_MAX_PRE, 32'h2710);
      wrr(OFF_SPC, 32'h3);
      repeat (150) @(posedge clk);
      rdc(OFF_MAX_LEN, 32'h1A_AAAA);
      rdc(OFF_MAX_REC, 32'h64);
      wrr(OFF_SPC, 32'h0);
      wrr(OFF_LEN, 32'h14);
      repeat (150) @(posedge clk);
      rdc(OFF_MAX_PRE, 32'hC8);
      wrr(OFF_ANALOG, 32'h15);
      repeat (150) @(posedge clk);
      stc(ST_BAD_CFG);
      wrr(OFF_ANALOG, 32'h8);
      wrr(OFF_BIN_CNT, 32'h0);
      repeat (150) @(posedge clk);
      rdc(OFF_MAX_LEN, 32'h5_0000);
      wrr(OFF_BIN_CNT, 32'h8);
      wrr(OFF_PRE, 32'h3);
      repeat (150) @(posedge clk);
      stc(ST_BAD_CFG);
      wrr(OFF_PRE, 32'h2);
      repeat (150) @(posedge clk);
      trail.delete();
      wrr(OFF_MAN_TRIG, CMD_TRIG);
      walk(ST_READY);
      rdc(OFF_MAN_TRIG, 32'h0);
      wrr(OFF_CTRL, {31'h0, REC_DISABLED});
      wrr(OFF_MAN_TRIG, CMD_TRIG);
      repeat (10 * T) @(posedge clk);
      wrr(OFF_CTRL, {31'h0, REC_ENABLED});
      repeat (10 * T) @(posedge clk);
      cc(exp_cnt);
      wrr(OFF_TRIG_LO, 32'h8);
      trail.delete();
      bin <= 32'h8;
      walk(ST_READY);
      wrr(OFF_TRIG_LO, 32'h0);
      wrr(OFF_TRIG_HI, 32'h4);
      trail.delete();
      ph <= 1'b1;
      walk(ST_READY);
      wrr(OFF_TRIG_HI, 32'h8);
      trail.delete();
      syn <= 1'b1;
      walk(ST_READY);
      wrr(OFF_TRIG_HI, 32'h0);
      while (exp_cnt < 100) begin
         trail.delete();
         wrr(OFF_MAN_TRIG, CMD_TRIG);
         walk(exp_cnt == 99 ? ST_FULL : ST_READY);
      end
      wrr(OFF_MAN_TRIG, CMD_TRIG);
      repeat (10 * T) @(posedge clk);
      cc(100);
      stc(ST_FULL);
      bus(1'b0, OFF_OLD_TIME, 32'h0, o);
      bus(1'b0, OFF_NEW_TIME, 32'h0, nw);
      wrr(OFF_CLR_NEW, CMD_CLEAR);
      rdc(OFF_OLD_TIME, o);
      cc(99);
      bus(1'b0, OFF_NEW_TIME, 32'h0, nw);
      wrr(OFF_CLR_OLD, CMD_CLEAR);
      rdc(OFF_NEW_TIME, nw);
      cc(98);
      bus(1'b0, OFF_OLD_TIME, 32'h0, v);
      chk("oldest moved", 40'h1, {39'h0, v > o});
      o = v;
      wrr(OFF_CLR_IDX, 32'h0);
      wrr(OFF_CLR_IDX, 32'h63);
      wrr(OFF_CLR_ALL, 32'h2);
      cc(98);
      wrr(OFF_CLR_IDX, 32'hA);
      rdc(OFF_OLD_TIME, o);
      rdc(OFF_NEW_TIME, nw);
      cc(97);
      wrr(OFF_CLR_ALL, CMD_CLEAR);
      rdc(OFF_OLD_TIME, 32'h0);
      cc(0);
      stc(ST_READY);
      end_sim();
   end
endmodule
